// [rtl/crs_pkg.sv]
// ****************************************************************
// Shared constants and types of the core register and skip block
// ****************************************************************
package crs_pkg;

	// Widths of the architectural registers, and the depth of the stack
	localparam int PC_W = 14;
	localparam int HALF_W = 7;
	localparam int SP_W = 3;
	localparam int STACK_DEPTH = 8;
	localparam int DP_W = 10;
	localparam int CNT_W = 2;

	// Values after reset
	localparam logic [13:0] PC_RESET = 14'h0000;
	localparam logic [2:0] SP_RESET = 3'h7; // First push lands in entry 0
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam logic [1:0] BANK_RESET = 2'h0;
	localparam logic [2:0] IDX_RESET = 3'h0;

	// Cycle counts of the multi-cycle instructions when executed
	localparam logic [1:0] TABLE_CALL_CYCLES = 2'h3;
	localparam logic [1:0] RETURN_CYCLES = 2'h2;
	localparam logic [1:0] ONE_CYCLE = 2'h1;

	// Instruction classes as seen by the sequencing logic
	typedef enum logic [5:0]
	{
		CRS_OP_SEQ = 6'h01,
		CRS_OP_JUMP = 6'h02,
		CRS_OP_CALL = 6'h04,
		CRS_OP_TABLE = 6'h08,
		CRS_OP_RET = 6'h10,
		CRS_OP_RET_SKIP = 6'h20
	} crs_op_t;

	// Decoded instruction presented at the start of its slot
	typedef struct packed
	{
		crs_op_t op;
		logic skip_cond;
		logic x_wr;
		logic y_wr;
		logic z_wr;
		logic dr_wr;
		logic [3:0] nibble;
		logic [13:0] target;
	} crs_instr_t;

endpackage

// [rtl/crs_return_stack.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Return address stack: one write port, one asynchronous read port
// ****************************************************************
module crs_return_stack #(
	parameter int DEPTH = crs_pkg::STACK_DEPTH,
	parameter int WIDTH = crs_pkg::PC_W,
	parameter int AW = crs_pkg::SP_W
) (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);

	logic [WIDTH-1:0] entry_mem [DEPTH];

	// Entries carry no reset; software never reads an entry it did not push
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			entry_mem[wr_addr_in] <= wr_data_in;
		end
	end

	assign rd_data_out = entry_mem[rd_addr_in];

endmodule
`default_nettype wire

// [rtl/crs_core_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Met skip condition nullifies the next instruction
// - Skip never adds two to the counter
// - Skipping instruction costs same cycles either way
// - Nullified table call or return takes one cycle
// - Data pointer is bank, file, word concatenated
// - Counter is page half above line half
// - Eight fourteen-bit stack entries, three-bit pointer
module crs_core_regs (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic slot_start_in,
	input wire crs_pkg::crs_instr_t instr_in,
	output logic [crs_pkg::DP_W-1:0] data_pointer_out,
	output logic [crs_pkg::PC_W-1:0] program_counter_out,
	output logic [crs_pkg::SP_W-1:0] stack_pointer_out,
	output logic [2:0] three_bit_index_reg_out,
	output logic nullify_out,
	output logic busy_out
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed
	{
		logic [6:0] counter_page_half;
		logic [6:0] counter_line_half;
		logic [1:0] bank;
		logic [3:0] file;
		logic [3:0] word;
		logic [2:0] index;
		logic [2:0] sp;
		logic skip;
		logic [1:0] cnt;
		logic tbl;
		logic busy;
	} crs_state_t;

	crs_state_t s_reg;
	crs_state_t s_next;
	logic push_en;
	logic [crs_pkg::SP_W-1:0] push_addr;
	logic [crs_pkg::PC_W-1:0] push_data;
	logic [crs_pkg::PC_W-1:0] top_word;
	logic [crs_pkg::PC_W-1:0] pc_now;
	logic [crs_pkg::PC_W-1:0] pc_inc;
	logic execute;
	logic nullify_slot;

	assign pc_now = {s_reg.counter_page_half, s_reg.counter_line_half};
	assign pc_inc = pc_now + 14'h0001;
	assign execute = slot_start_in && (s_reg.cnt == 2'h0) && !s_reg.skip;
	assign nullify_slot = slot_start_in && (s_reg.cnt == 2'h0) && s_reg.skip;

	// ****************************************************************
	// Return stack
	// ****************************************************************
	crs_return_stack #(
		.DEPTH(crs_pkg::STACK_DEPTH),
		.WIDTH(crs_pkg::PC_W),
		.AW(crs_pkg::SP_W)
	) u_stack (
		.clk_in(clk_in),
		.wr_en_in(push_en),
		.wr_addr_in(push_addr),
		.wr_data_in(push_data),
		.rd_addr_in(s_reg.sp),
		.rd_data_out(top_word)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Sequencing: finish multi-cycle work, else take a slot
	always_comb
	begin
		s_next = s_reg;
		push_en = 1'b0;
		push_addr = s_reg.sp + 3'h1;
		push_data = pc_inc;
		if (s_reg.cnt != 2'h0)
		begin
			s_next.cnt = s_reg.cnt - 2'h1;
			// Table read returns only after its data cycles
			if ((s_reg.cnt == crs_pkg::ONE_CYCLE) && s_reg.tbl)
			begin
				{s_next.counter_page_half, s_next.counter_line_half} = top_word;
				s_next.sp = s_reg.sp - 3'h1;
				s_next.tbl = 1'b0;
			end
		end
		else if (nullify_slot)
		begin
			// Fetch slot is spent, one cycle, no writes whatever the class
			s_next.skip = 1'b0;
			{s_next.counter_page_half, s_next.counter_line_half} = pc_inc;
		end
		else if (execute)
		begin
			s_next.skip = instr_in.skip_cond;
			if (instr_in.x_wr)
			begin
				s_next.file = instr_in.nibble;
			end
			if (instr_in.y_wr)
			begin
				s_next.word = instr_in.nibble;
			end
			if (instr_in.z_wr)
			begin
				s_next.bank = instr_in.nibble[1:0];
			end
			if (instr_in.dr_wr)
			begin
				s_next.index = instr_in.nibble[2:0];
			end
			{s_next.counter_page_half, s_next.counter_line_half} = pc_inc;
			case (instr_in.op)
				crs_pkg::CRS_OP_SEQ:
				begin
					s_next.cnt = 2'h0;
				end
				crs_pkg::CRS_OP_JUMP:
				begin
					{s_next.counter_page_half, s_next.counter_line_half} = instr_in.target;
				end
				crs_pkg::CRS_OP_CALL:
				begin
					push_en = 1'b1;
					s_next.sp = s_reg.sp + 3'h1;
					{s_next.counter_page_half, s_next.counter_line_half} = instr_in.target;
				end
				crs_pkg::CRS_OP_TABLE:
				begin
					// Line half is index register over the accumulator nibble
					push_en = 1'b1;
					s_next.sp = s_reg.sp + 3'h1;
					s_next.counter_page_half = instr_in.target[13:7];
					s_next.counter_line_half = {s_reg.index, instr_in.nibble};
					s_next.cnt = crs_pkg::TABLE_CALL_CYCLES - 2'h1;
					s_next.tbl = 1'b1;
				end
				crs_pkg::CRS_OP_RET, crs_pkg::CRS_OP_RET_SKIP:
				begin
					{s_next.counter_page_half, s_next.counter_line_half} = top_word;
					s_next.sp = s_reg.sp - 3'h1;
					s_next.cnt = crs_pkg::RETURN_CYCLES - 2'h1;
					s_next.skip = instr_in.skip_cond || (instr_in.op == crs_pkg::CRS_OP_RET_SKIP);
				end
				default:
				begin
					s_next.cnt = 2'h0;
				end
			endcase
		end
		s_next.busy = (s_next.cnt != 2'h0); // Own flop, so the output needs no decode after the clock
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Only constants under reset
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			s_reg.counter_page_half <= crs_pkg::PC_RESET[13:7];
			s_reg.counter_line_half <= crs_pkg::PC_RESET[6:0];
			s_reg.bank <= crs_pkg::BANK_RESET;
			s_reg.file <= crs_pkg::NIB_RESET;
			s_reg.word <= crs_pkg::NIB_RESET;
			s_reg.index <= crs_pkg::IDX_RESET;
			s_reg.sp <= crs_pkg::SP_RESET;
			s_reg.skip <= 1'b0;
			s_reg.cnt <= 2'h0;
			s_reg.tbl <= 1'b0;
			s_reg.busy <= 1'b0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// Outputs are plain flop bits; the pointer is a wiring of three registers
	assign data_pointer_out = {s_reg.bank, s_reg.file, s_reg.word};
	assign program_counter_out = pc_now;
	assign stack_pointer_out = s_reg.sp;
	assign three_bit_index_reg_out = s_reg.index;
	assign nullify_out = s_reg.skip; // Datapath gates every write in a slot while high
	assign busy_out = s_reg.busy;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_null_slot;
		slot_start_in && !busy_out && nullify_out;
	endsequence

	sequence s_table_start;
		execute && (instr_in.op == crs_pkg::CRS_OP_TABLE);
	endsequence

	property p_null_clears;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_null_slot |=> !nullify_out;
	endproperty
	a_null_clears: assert property (p_null_clears) else $error("skip flag not cleared");

	property p_skip_next;
		@(posedge clk_in) disable iff (!reset_n_in)
		(execute && instr_in.skip_cond) |=> nullify_out;
	endproperty
	a_skip_next: assert property (p_skip_next) else $error("met skip did not arm nullify");

	property p_null_plus_one;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_null_slot |=> (program_counter_out == $past(program_counter_out) + 14'h0001);
	endproperty
	a_null_plus_one: assert property (p_null_plus_one) else $error("counter not advanced by one");

	property p_same_cycles;
		@(posedge clk_in) disable iff (!reset_n_in)
		(execute && (instr_in.op == crs_pkg::CRS_OP_SEQ)) |=> !busy_out;
	endproperty
	a_same_cycles: assert property (p_same_cycles) else $error("skip changed cycle count");

	property p_null_one_cycle;
		@(posedge clk_in) disable iff (!reset_n_in)
		(s_null_slot ##0 (instr_in.op != crs_pkg::CRS_OP_SEQ)) |=> !busy_out;
	endproperty
	a_null_one_cycle: assert property (p_null_one_cycle) else $error("nullified op not one cycle");

	property p_table_length;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_table_start |=> busy_out [*2] ##1 (!busy_out && (stack_pointer_out == $past(stack_pointer_out, 3)));
	endproperty
	a_table_length: assert property (p_table_length) else $error("table call length or pointer wrong");

	property p_pointer_word;
		@(posedge clk_in) disable iff (!reset_n_in)
		(execute && instr_in.x_wr) |=> (data_pointer_out[7:4] == $past(instr_in.nibble));
	endproperty
	a_pointer_word: assert property (p_pointer_word) else $error("file field misplaced");

	property p_jump_halves;
		@(posedge clk_in) disable iff (!reset_n_in)
		(execute && (instr_in.op == crs_pkg::CRS_OP_JUMP)) |=>
			(program_counter_out[13:7] == $past(instr_in.target[13:7])) &&
			(program_counter_out[6:0] == $past(instr_in.target[6:0]));
	endproperty
	a_jump_halves: assert property (p_jump_halves) else $error("jump halves wrong");

	property p_call_push;
		@(posedge clk_in) disable iff (!reset_n_in)
		(execute && (instr_in.op == crs_pkg::CRS_OP_CALL)) |=>
			(stack_pointer_out == $past(stack_pointer_out) + 3'h1) && (top_word == $past(pc_inc));
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong");

	property p_null_frozen;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_null_slot |=> $stable(data_pointer_out) && $stable(stack_pointer_out) && $stable(three_bit_index_reg_out);
	endproperty
	a_null_frozen: assert property (p_null_frozen) else $error("nullified op changed state");

endmodule
`default_nettype wire

// [verif/crs_datapath_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Datapath stand-in: counts slots that write and slots dropped
// ****************************************************************
module crs_datapath_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic slot_start_in,
	input wire logic busy_in,
	input wire logic nullify_in,
	input wire crs_pkg::crs_instr_t instr_in,
	output logic [7:0] write_count_out,
	output logic [7:0] drop_count_out
);
	// A flagged slot makes no write, whatever it asks for
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			write_count_out <= 8'h00;
			drop_count_out <= 8'h00;
		end
		else if (slot_start_in && !busy_in)
		begin
			if (nullify_in)
				drop_count_out <= drop_count_out + 8'h01;
			else if (instr_in.x_wr | instr_in.y_wr | instr_in.z_wr | instr_in.dr_wr)
				write_count_out <= write_count_out + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [verif/cpu_core_regs_and_skip_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_core_regs_and_skip_tb_top;
	typedef struct {crs_pkg::crs_instr_t i; logic [1:0] cyc; logic [13:0] pc; logic [2:0] sp; logic nul; logic [9:0] dp;} crs_row_t;
	localparam crs_pkg::crs_op_t os = crs_pkg::CRS_OP_SEQ;
	localparam crs_pkg::crs_op_t oj = crs_pkg::CRS_OP_JUMP;
	localparam crs_pkg::crs_op_t oc = crs_pkg::CRS_OP_CALL;
	localparam crs_pkg::crs_op_t ot = crs_pkg::CRS_OP_TABLE;
	localparam crs_pkg::crs_op_t orr = crs_pkg::CRS_OP_RET;
	localparam crs_pkg::crs_op_t oq = crs_pkg::CRS_OP_RET_SKIP;
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic slot = 1'h0;
	crs_pkg::crs_instr_t instr = '0;
	logic [9:0] dp;
	logic [13:0] pc;
	logic [2:0] sp, idx;
	logic nul, busy;
	logic [7:0] wr_cnt, drop_cnt;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int exp_drop = 0;
	crs_row_t rows [22];
	// Clock of 20 ns
	always #10 clk_in = ~clk_in;
	crs_core_regs i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .slot_start_in(slot), .instr_in(instr),
		.data_pointer_out(dp), .program_counter_out(pc), .stack_pointer_out(sp),
		.three_bit_index_reg_out(idx), .nullify_out(nul), .busy_out(busy));
	crs_datapath_model i_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .slot_start_in(slot), .busy_in(busy),
		.nullify_in(nul), .instr_in(instr), .write_count_out(wr_cnt), .drop_count_out(drop_cnt));
	function automatic crs_pkg::crs_instr_t mk(input crs_pkg::crs_op_t op, input logic sk, input logic [3:0] w,
		input logic [3:0] n, input logic [13:0] t);
		return '{op, sk, w[3], w[2], w[1], w[0], n, t};
	endfunction
	task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Slot held up through the busy cycles, so an early or late end shows
	task automatic step(input crs_row_t r);
		slot <= 1'h1;
		instr <= r.i;
		repeat (r.cyc) @(posedge clk_in);
		slot <= 1'h0;
		@(negedge clk_in);
		chk("pc", r.pc, pc);
		chk("sp", 14'(r.sp), 14'(sp));
		chk("nullify", 14'(r.nul), 14'(nul));
		chk("dp", 14'(r.dp), 14'(dp));
		chk("busy", 14'h0000, 14'(busy));
		@(posedge clk_in);
	endtask
	task automatic rst_chk();
		chk("pc", 14'h0000, pc);
		chk("sp", 14'h0007, 14'(sp));
		chk("dp", 14'h0000, 14'(dp));
		chk("flags", 14'h0000, 14'({idx, nul, busy}));
	endtask
	// Hang guard well above the expected run length
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 1000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		rows = '{'{mk(os, 0, 8, 5, 0), 1, 14'h0001, 3'h7, 0, 10'h050}, '{mk(os, 0, 4, 10, 0), 1, 14'h0002, 3'h7, 0, 10'h05a},
			'{mk(os, 0, 2, 3, 0), 1, 14'h0003, 3'h7, 0, 10'h35a}, '{mk(os, 0, 1, 6, 0), 1, 14'h0004, 3'h7, 0, 10'h35a},
			'{mk(oj, 0, 0, 0, 14'h0105), 1, 14'h0105, 3'h7, 0, 10'h35a}, '{mk(oc, 0, 0, 0, 14'h1f00), 1, 14'h1f00, 3'h0, 0, 10'h35a},
			'{mk(ot, 0, 0, 4, 14'h0a80), 3, 14'h1f01, 3'h0, 0, 10'h35a}, '{mk(orr, 0, 0, 0, 0), 2, 14'h0106, 3'h7, 0, 10'h35a},
			'{mk(os, 0, 0, 0, 0), 1, 14'h0107, 3'h7, 0, 10'h35a}, '{mk(os, 1, 0, 0, 0), 1, 14'h0108, 3'h7, 1, 10'h35a},
			'{mk(oc, 0, 8, 15, 14'h0200), 1, 14'h0109, 3'h7, 0, 10'h35a}, '{mk(os, 1, 0, 0, 0), 1, 14'h010a, 3'h7, 1, 10'h35a},
			'{mk(ot, 0, 0, 0, 0), 1, 14'h010b, 3'h7, 0, 10'h35a}, '{mk(os, 1, 0, 0, 0), 1, 14'h010c, 3'h7, 1, 10'h35a},
			'{mk(orr, 0, 0, 0, 0), 1, 14'h010d, 3'h7, 0, 10'h35a}, '{mk(os, 1, 0, 0, 0), 1, 14'h010e, 3'h7, 1, 10'h35a},
			'{mk(oq, 0, 0, 0, 0), 1, 14'h010f, 3'h7, 0, 10'h35a}, '{mk(oc, 0, 0, 0, 14'h3fff), 1, 14'h3fff, 3'h0, 0, 10'h35a},
			'{mk(oq, 0, 0, 0, 0), 2, 14'h0110, 3'h7, 1, 10'h35a}, '{mk(os, 0, 8, 15, 0), 1, 14'h0111, 3'h7, 0, 10'h35a},
			'{mk(oj, 0, 0, 0, 14'h007f), 1, 14'h007f, 3'h7, 0, 10'h35a}, '{mk(os, 0, 0, 0, 0), 1, 14'h0080, 3'h7, 0, 10'h35a}};
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		rst_chk();
		@(posedge clk_in);
		reset_n_in <= 1'h1;
		foreach (rows[k])
		begin
			if (k > 0 && rows[k - 1].nul)
				exp_drop++;
			step(rows[k]);
		end
		chk("writes", 14'h0004, 14'(wr_cnt));
		chk("drops", 14'(exp_drop), 14'(drop_cnt));
		chk("index", 14'h0006, 14'(idx));
		$display("test rows done");
		// Fill all eight entries, then unwind them in reverse
		for (int k = 0; k < 8; k++)
			step('{mk(oc, 0, 0, 0, 14'h0800 + 14'(k * 16)), 1, 14'h0800 + 14'(k * 16), 3'(k), 0, 10'h35a});
		for (int j = 7; j >= 0; j--)
			step('{mk(orr, 0, 0, 0, 0), 2, (j == 0) ? 14'h0081 : 14'h0801 + 14'((j - 1) * 16), 3'(j - 1), 0, 10'h35a});
		$display("test stack done");
		reset_n_in <= 1'h0;
		@(negedge clk_in);
		rst_chk();
		@(posedge clk_in);
		reset_n_in <= 1'h1;
		step('{mk(os, 1, 2, 1, 0), 1, 14'h0001, 3'h7, 1, 10'h100});
		$display("test reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
